//--- flash_self_program_pkg.sv
package flash_self_program_pkg;
  // register offsets (sfr address times four on the apb word map)
  localparam logic [11:0] ADDR_SYSTEM_CONTROL   = 12'h2fc; // sfr bf
  localparam logic [11:0] ADDR_FLASH_ADDR_HIGH  = 12'h3d0; // sfr f4
  localparam logic [11:0] ADDR_FLASH_ADDR_LOW   = 12'h3d4; // sfr f5
  localparam logic [11:0] ADDR_FLASH_DATA_BYTE  = 12'h3d8; // sfr f6
  localparam logic [11:0] ADDR_FLASH_OP_CONTROL = 12'h3dc; // sfr f7
  localparam logic [11:0] ADDR_FLASH_STATUS     = 12'h3e0; // own status word
  localparam logic [11:0] ADDR_FLASH_READ       = 12'h3e4; // own read port
  // field positions
  localparam int BIT_SELF_PROGRAM_ENABLE = 2;
  localparam int BIT_OP_LAUNCH           = 7;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // erase fill value and protected read value
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [7:0] PROTECTED_BYTE = 8'h00;
  // page geometry: 512 bytes, page base has high-byte lsb clear
  localparam logic [7:0] PAGE_LOW_FIRST = 8'h00;
  localparam logic [7:0] PAGE_LOW_LAST  = 8'hff;
  // boot loader region starts at this high byte (parameterised in top)
  localparam logic [7:0] BOOT_BASE_HIGH_DEFAULT = 8'hfe;
  // time per byte written, and per erased location step
  localparam int PROGRAM_TIME_NS = 40;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int PROGRAM_CYCLES  = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operation select codes
  typedef enum logic [1:0] {
    OP_BYTE_PROGRAM = 2'b00,
    OP_ERASE_PROTECT = 2'b01,
    OP_PAGE_ERASE   = 2'b10,
    OP_ARRAY_ERASE  = 2'b11
  } flash_op_t;

  // captured operands
  typedef struct packed {
    flash_op_t  op;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic [7:0] data;
  } flash_operands_t;

  // memory write port
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_write_t;
endpackage

//--- flash_array_mem.sv
`timescale 1ns/1ps
module flash_array_mem
  import flash_self_program_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // write port
  input  wire mem_write_t i_wr,
  // read port
  input  wire logic [15:0] i_rd_addr,
  output logic [7:0]       o_rd_data
);
  logic [7:0] cells [0:65535]; // flash array model, no reset on purpose

  // write and registered read
  always_ff @(posedge i_clk) begin
    if (i_wr.en) begin
      cells[i_wr.addr] <= i_wr.data;
    end
    o_rd_data <= cells[i_rd_addr];
  end
endmodule

//--- flash_self_program_control.sv
`timescale 1ns/1ps
// Function
// - op codes program, protect, page, whole erase
// - launch bit read-only after reset
// - 55 aa 55 to data byte unlocks launch
// - launch captures address and data operands
// - stall program counter while operation runs
// - completion clears launch bit, releases counter
// - byte program writes data at 16-bit address
// - page erase acts on 512-byte pages
// - page range from high byte, its lsb ignored
// - boot loader pages never page-erased
// - array erase spares boot loader region
// - array erase removes read protection
// - protected flash reads return 00h
// - self programming disabled after reset
// - high and low form 16-bit address
module flash_self_program_control
  import flash_self_program_pkg::*;
#(
  parameter logic [7:0] BOOT_BASE_HIGH = BOOT_BASE_HIGH_DEFAULT // boot region base, high byte
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core interface
  output logic             o_pc_hold,
  output logic             o_busy
);
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_RUN    = 2'b10,
    ST_FINISH = 2'b11
  } seq_state_t;

  // software registers
  logic [7:0]      sysctl_q;       // system_control
  logic [7:0]      addr_high_q;    // flash_addr_high
  logic [7:0]      addr_low_q;     // flash_addr_low
  logic [7:0]      data_byte_q;    // flash_data_byte
  logic [1:0]      op_select_q;    // flash_op_select
  logic            launch_q;       // op_launch_bit
  logic [1:0]      unlock_q;       // key bytes matched so far
  logic            protect_q;      // read protection active
  logic [15:0]     read_addr_q;    // address for read port
  // sequencer
  // range counters are only meaningful while the launch bit is set
  seq_state_t      state_q;
  flash_operands_t opnd_q;         // captured operands
  logic [15:0]     cur_q;          // current erase address
  logic [15:0]     end_q;          // last erase address
  logic [7:0]      wait_q;         // per-location timing
  logic [7:0]      mem_rd;         // raw array read

  // apb decode, taken in the access cycle only
  wire access   = psel && penable;
  // every register but the 16-bit read port address is one byte wide; only the low strobe is checked
  wire wr       = access && pwrite && pstrb[0];
  wire rd       = access && !pwrite;
  // full-address compares: no offset aliases onto another register
  wire hit_sys  = paddr == ADDR_SYSTEM_CONTROL;
  wire hit_ahi  = paddr == ADDR_FLASH_ADDR_HIGH;
  wire hit_alo  = paddr == ADDR_FLASH_ADDR_LOW;
  wire hit_dat  = paddr == ADDR_FLASH_DATA_BYTE;
  wire hit_ctl  = paddr == ADDR_FLASH_OP_CONTROL;
  wire hit_sta  = paddr == ADDR_FLASH_STATUS;
  wire hit_rdp  = paddr == ADDR_FLASH_READ;
  wire mapped   = hit_sys | hit_ahi | hit_alo | hit_dat | hit_ctl | hit_sta | hit_rdp;
  wire enable   = sysctl_q[BIT_SELF_PROGRAM_ENABLE];
  wire unlocked = unlock_q == 2'd3;
  // launch accepted only when unlocked and enabled
  wire launch   = wr && hit_ctl && pwdata[BIT_OP_LAUNCH] && unlocked
                  && enable && !launch_q;
  // after the first key byte the second must follow, otherwise the first again
  wire key_hit  = (unlock_q == 2'd1) ? (pwdata[7:0] == KEY_SECOND)
                                     : (pwdata[7:0] == KEY_FIRST);

  // page bounds: clear the high-byte lsb to get the 512-byte base
  function automatic logic [15:0] page_base(input logic [7:0] hi);
    page_base = {hi[7:1], 1'b0, PAGE_LOW_FIRST};
  endfunction
  // boot region: everything at or above the base high byte
  function automatic logic in_boot(input logic [15:0] a);
    in_boot = a[15:8] >= BOOT_BASE_HIGH;
  endfunction

  // page span from the captured high byte, odd or even alike
  wire [15:0] pg_first = page_base(opnd_q.addr_high);
  wire [15:0] pg_last  = {opnd_q.addr_high[7:1], 1'b1, PAGE_LOW_LAST};

  // apb answers in the access cycle, no wait states
  // a launch never stalls the bus: the stall goes to the core instead
  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && launch_q)); // writes refused while busy

  // read data straight from the registers during the access cycle
  // unmapped offsets read as zero; pslverr reports them
  logic [7:0] rd_mux;
  assign rd_mux = hit_sys ? sysctl_q :
                  hit_ahi ? addr_high_q :
                  hit_alo ? addr_low_q :
                  hit_dat ? data_byte_q :
                  hit_ctl ? {launch_q, 5'b0, op_select_q} :
                  hit_sta ? {4'b0, protect_q, unlocked, o_busy, enable} :
                  hit_rdp ? (protect_q ? PROTECTED_BYTE : mem_rd) : RESET_BYTE;
  always_comb begin
    prdata = {24'h0, rd_mux};
  end

  // software registers, writes blocked while an operation runs
  // limitation: a refused write is dropped whole, not queued
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sysctl_q    <= RESET_BYTE;
      addr_high_q <= RESET_BYTE;
      addr_low_q  <= RESET_BYTE;
      data_byte_q <= RESET_BYTE;
      op_select_q <= OP_BYTE_PROGRAM;
      read_addr_q <= 16'h0000;
    end else if (wr && !launch_q) begin
      if (hit_sys) sysctl_q <= pwdata[7:0];
      if (hit_ahi) addr_high_q <= pwdata[7:0];
      if (hit_alo) addr_low_q <= pwdata[7:0];
      if (hit_dat) data_byte_q <= pwdata[7:0];
      // op select stays writable even when the launch itself is refused
      if (hit_ctl) op_select_q <= pwdata[1:0];
      if (hit_rdp) read_addr_q <= pwdata[15:0];
    end
  end

  // unlock tracker; once unlocked, later data byte writes leave it alone
  // a refused launch keeps the unlock, only a real launch consumes it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      unlock_q <= 2'd0;
    end else if (launch) begin
      unlock_q <= 2'd0;
    end else if (wr && hit_dat && !launch_q && !unlocked) begin
      // a wrong byte restarts, but a fresh 55 counts as step one
      unlock_q <= key_hit ? unlock_q + 2'd1
                : (pwdata[7:0] == KEY_FIRST ? 2'd1 : 2'd0);
    end
  end

  // launch bit and sequencer
  mem_write_t mem_wr;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      launch_q  <= 1'b0;
      state_q   <= ST_IDLE;
      opnd_q    <= '0;
      cur_q     <= 16'h0000;
      end_q     <= 16'h0000;
      wait_q    <= 8'h00;
      protect_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // operands are frozen here so later register writes cannot disturb the run
          if (launch) begin
            launch_q <= 1'b1;
            opnd_q   <= '{op: flash_op_t'(pwdata[1:0]), addr_high: addr_high_q,
                          addr_low: addr_low_q, data: data_byte_q};
            state_q  <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // set range per operation
          // byte program and protect use a one-location range
          wait_q <= 8'(PROGRAM_CYCLES);
          unique case (opnd_q.op)
            OP_PAGE_ERASE: begin
              cur_q <= pg_first;
              end_q <= pg_last;
            end
            OP_ARRAY_ERASE: begin
              cur_q <= 16'h0000;
              end_q <= {BOOT_BASE_HIGH, PAGE_LOW_FIRST} - 16'h0001;
            end
            default: begin
              cur_q <= {opnd_q.addr_high, opnd_q.addr_low};
              end_q <= {opnd_q.addr_high, opnd_q.addr_low};
            end
          endcase
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          // one location per timing step; protect and boot pages write nothing
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else if (cur_q == end_q || opnd_q.op == OP_ERASE_PROTECT
                       || (opnd_q.op == OP_PAGE_ERASE && in_boot(pg_first))) begin
            state_q <= ST_FINISH;
          end else begin
            cur_q  <= cur_q + 16'h0001;
            wait_q <= 8'(PROGRAM_CYCLES);
          end
        end
        ST_FINISH: begin
          // protection only changes once the operation has ended
          if (opnd_q.op == OP_ERASE_PROTECT) protect_q <= 1'b1;
          if (opnd_q.op == OP_ARRAY_ERASE) protect_q <= 1'b0;
          launch_q <= 1'b0;
          state_q  <= ST_IDLE;
        end
      endcase
    end
  end

  // array write: one location at the end of each timing step
  // trade-off: erase walks byte by byte, simple but slow for a whole array
  wire step_done = state_q == ST_RUN && wait_q == 8'h00;
  wire boot_page = opnd_q.op == OP_PAGE_ERASE && in_boot(pg_first);
  assign mem_wr = '{en:   step_done && opnd_q.op != OP_ERASE_PROTECT && !boot_page,
                    addr: cur_q,
                    data: (opnd_q.op == OP_BYTE_PROGRAM) ? opnd_q.data : ERASED_BYTE};

  // core stall: hold is the launch bit itself, so both drop on one edge
  // busy mirrors hold for software that polls the status word
  assign o_pc_hold = launch_q;
  assign o_busy    = launch_q;

  // flash array; its read data lag the read address by one cycle
  flash_array_mem u_mem (
    .i_clk     (i_clk),
    .i_wr      (mem_wr),
    .i_rd_addr (read_addr_q),
    .o_rd_data (mem_rd)
  );

  // checks
  a_launch_locked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!launch_q && !unlocked) |=> !launch_q) else $error("launch without unlock");
  a_launch_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!launch_q && !enable) |=> !launch_q) else $error("launch while disabled");
  a_pc_hold_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q != ST_IDLE |-> o_pc_hold) else $error("pc not held");
  a_unlock_used: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    launch |=> unlock_q == 2'd0) else $error("unlock not consumed");
  a_launch_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == ST_FINISH |=> !launch_q && !o_pc_hold) else $error("launch not cleared");
  a_capture_ops: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    launch |=> opnd_q.addr_high == $past(addr_high_q) && opnd_q.data == $past(data_byte_q))
    else $error("operands not captured");
  a_boot_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mem_wr.en && opnd_q.op != OP_BYTE_PROGRAM |-> !in_boot(mem_wr.addr))
    else $error("boot region written");
  a_protect_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    protect_q && rd && hit_rdp |-> prdata == 32'h0) else $error("protected read leaked");
  a_unprotect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == ST_FINISH && opnd_q.op == OP_ARRAY_ERASE |=> !protect_q)
    else $error("protection kept");
  a_page_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mem_wr.en && opnd_q.op == OP_PAGE_ERASE |-> mem_wr.addr[15:9] == opnd_q.addr_high[7:1])
    else $error("page erase out of page");
  // launch walks through load into run on consecutive edges
  sequence s_load_then_run;
    state_q == ST_LOAD ##1 state_q == ST_RUN;
  endsequence
  a_launch_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    launch |=> s_load_then_run) else $error("launch did not start the sequencer");
  // a write while busy must leave the operand registers alone
  a_busy_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr && o_busy |=> $stable(addr_low_q) && $stable(data_byte_q))
    else $error("busy write taken");
  // reset leaves self programming off and the launch bit clear
  a_enable_reset: assert property (@(posedge i_clk)
    !i_rst_n |=> !enable && !launch_q) else $error("not idle after reset");
  // byte program lands exactly at the captured address with the captured data
  a_prog_target: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mem_wr.en && opnd_q.op == OP_BYTE_PROGRAM
      |-> mem_wr.addr == {opnd_q.addr_high, opnd_q.addr_low} && mem_wr.data == opnd_q.data)
    else $error("byte written to wrong place");
  // erases only ever write the erased value
  a_erase_fill: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mem_wr.en && opnd_q.op != OP_BYTE_PROGRAM |-> mem_wr.data == ERASED_BYTE)
    else $error("erase wrote data");
  // erase protect touches no array location
  a_protect_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q != ST_IDLE && opnd_q.op == OP_ERASE_PROTECT |-> !mem_wr.en)
    else $error("protect wrote the array");
  // a wrong key byte that is not the first key throws the count away
  a_unlock_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr && hit_dat && !launch_q && !unlocked && !key_hit && pwdata[7:0] != KEY_FIRST
      |=> unlock_q == 2'd0) else $error("wrong key byte kept");
  // a byte program ends within a few cycles and drops the launch bit
  a_byte_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    launch && pwdata[1:0] == OP_BYTE_PROGRAM |-> ##[1:8] !launch_q)
    else $error("byte program did not finish");
endmodule

//--- core_pc_model.sv
`timescale 1ns/1ps
// far side: program counter of the core, advances one step a cycle
module core_pc_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // hold request from the flash controller
  input  wire logic        i_hold,
  // current program counter
  output logic      [15:0] o_pc
);
  logic [15:0] pc_q; // counter state
  logic [15:0] pc_d; // next counter value

  // frozen while held, otherwise fetches on
  assign pc_d = i_hold ? pc_q : pc_q + 16'h0001;
  assign o_pc = pc_q;

  // short register, sync reset like the core
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pc_q <= 16'h0000;
    else          pc_q <= pc_d;
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
  import flash_self_program_pkg::*;
;
  localparam logic [7:0] BOOT = 8'h10; // small boot base keeps array erase short
  logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, o_pc_hold, o_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] pc, p0;
  logic        er, bad;
  int          mismatches, n_compared, seed, n;
  logic [7:0]  mem [int]; // reference flash contents, only known bytes
  bit          prot;      // reference read protection

  flash_self_program_control #(.BOOT_BASE_HIGH(BOOT)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .o_pc_hold(o_pc_hold), .o_busy(o_busy));
  core_pc_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold(o_pc_hold), .o_pc(pc));

  // clock source
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // read a flash byte through the read port
  task automatic rdf(input logic [15:0] a);
    apb(1'b1, ADDR_FLASH_READ, {16'h0000, a});
    apb(1'b0, ADDR_FLASH_READ, 32'h0);
    chk(rd, prot ? 32'h0 : {24'h0, mem[a]});
  endtask

  task automatic unlock();
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'h55);
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'haa);
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'h55);
  endtask

  // launch expected to be refused: controller stays idle
  task automatic refused();
    apb(1'b1, ADDR_FLASH_OP_CONTROL, 32'h80);
    @(negedge i_clk);
    chk(o_busy, 1'b0);
  endtask

  // full operation with reference update and stall check
  task automatic run(input logic [1:0] op, input logic [7:0] hi, lo, dt);
    unlock();
    apb(1'b1, ADDR_SYSTEM_CONTROL, 32'h04);
    apb(1'b1, ADDR_FLASH_ADDR_HIGH, {24'h0, hi});
    apb(1'b1, ADDR_FLASH_ADDR_LOW, {24'h0, lo});
    apb(1'b1, ADDR_FLASH_DATA_BYTE, {24'h0, dt});
    apb(1'b1, ADDR_FLASH_OP_CONTROL, {24'h0, 6'h20, op});
    @(negedge i_clk);
    chk(o_pc_hold, 1'b1);
    p0 = pc;
    apb(1'b1, ADDR_FLASH_ADDR_LOW, 32'h3c); // operands already captured
    chk(er, 1'b1);
    bad = 1'b0;
    for (n = 0; n < 20000 && o_busy === 1'b1; n++) begin
      @(negedge i_clk);
      if (pc !== p0 && o_pc_hold === 1'b1) bad = 1'b1;
    end
    chk(bad, 1'b0);
    @(negedge i_clk);
    chk(pc != p0, 1'b1);
    apb(1'b0, ADDR_FLASH_OP_CONTROL, 32'h0);
    chk(rd[7], 1'b0);
    case (op)
      OP_BYTE_PROGRAM: mem[{hi, lo}] = dt;
      OP_ERASE_PROTECT: prot = 1'b1;
      OP_PAGE_ERASE: if (hi < BOOT) for (int i = 0; i < 512; i++)
        mem[{hi[7:1], 9'h000} + i] = 8'hff;
      default: begin
        for (int i = 0; i < BOOT * 256; i++) mem[i] = 8'hff;
        prot = 1'b0;
      end
    endcase
  endtask

  task automatic check_all();
    foreach (mem[a]) rdf(a[15:0]);
  endtask

  // hang guard
  initial begin
    repeat (95000) @(posedge i_clk);
    mismatches++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    i_rst_n = 1'b0; seed = 17; prot = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    pstrb <= 4'hf;
    apb(1'b0, ADDR_FLASH_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, ADDR_SYSTEM_CONTROL, 32'h04);
    refused();
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'h55);
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'haa);
    apb(1'b1, ADDR_FLASH_DATA_BYTE, 32'h12);
    refused();
    unlock();
    apb(1'b1, ADDR_SYSTEM_CONTROL, 32'h00);
    refused();
    for (int k = 0; k < 4; k++)
      run(OP_BYTE_PROGRAM, $random(seed) & 8'h0f, $random(seed), $random(seed));
    run(OP_BYTE_PROGRAM, 8'h12, 8'h34, 8'h5a);
    run(OP_BYTE_PROGRAM, 8'h04, 8'hff, 8'h11);
    run(OP_BYTE_PROGRAM, 8'h07, 8'h00, 8'h22);
    check_all();
    refused();
    run(OP_PAGE_ERASE, 8'h05, 8'h00, 8'h00);
    run(OP_PAGE_ERASE, 8'h12, 8'h00, 8'h00);
    check_all();
    run(OP_PAGE_ERASE, 8'h06, 8'h00, 8'h00);
    check_all();
    run(OP_ERASE_PROTECT, 8'h00, 8'h00, 8'h00);
    rdf(16'h1234);
    rdf(16'h0700);
    run(OP_ARRAY_ERASE, 8'h00, 8'h00, 8'h00);
    check_all();
    conclude();
  end
endmodule
